/* File: tb_watchdog_timer_with_mode_control.sv */
`timescale 1ns/1ps
module tb_watchdog_timer_with_mode_control;
    import wdm_pkg::*;
    typedef struct packed {
        logic [7:0] mode;
        int n;
    } wdm_row_t;
    localparam int WIN = 4;
    localparam int P_KICK = 0;
    localparam int P_GO = 1;
    localparam int P_RECOV = 2;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] rdat;
    logic [31:0] wb_q;
    logic halt = 1'b0;
    logic stop = 1'b0;
    logic strap = 1'b0;
    logic kick_req = 1'b0;
    logic go = 1'b0;
    logic recov = 1'b0;
    logic ack, wdt_rst, irq, instr, first, rc, xtal;
    int num_errors = 0;
    int cmp_count = 0;
    int ticks = 0;
    int c;
    wdm_row_t rows[6] = '{'{8'h0c, 128}, '{8'h0d, 256}, '{8'h0e, 512}, '{8'h0f, 2048},
        '{8'h1c, 128}, '{8'hee, 512}};

    wdm_watchdog #(.WIN_CYCLES(WIN)) i_wdm_watchdog (
        .i_core_clk(core_clk),
        .i_rst_b(rst_b),
        .i_wb_cyc(cyc),
        .i_wb_stb(stb),
        .i_wb_we(we),
        .i_wb_adr(adr),
        .i_wb_dat(dat),
        .i_wb_sel(sel),
        .o_wb_dat(rdat),
        .o_wb_ack(ack),
        .i_wdt_instr(instr),
        .i_first_instr(first),
        .i_stop_wake_recovery(recov),
        .i_halt_mode(halt),
        .i_stop_mode(stop),
        .i_rc_osc(rc),
        .i_crystal_input_pin(xtal),
        .i_perm_enable_opt(strap),
        .o_wdt_reset(wdt_rst),
        .o_irq(irq)
    );

    wdm_core_model i_wdm_core_model (
        .i_core_clk(core_clk),
        .i_kick(kick_req),
        .i_go(go),
        .i_stop_mode(stop),
        .o_wdt_instr(instr),
        .o_first_instr(first),
        .o_rc_osc(rc),
        .o_crystal_input_pin(xtal)
    );

    initial begin
        forever #25 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        ticks <= ticks + 1;
        if (ticks > 40000) begin
            num_errors++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // rc ticks every second cycle, plus edge-detect and handshake slack
    task automatic chk_time(input int n, input int seen);
        cmp_count++;
        if (seen < 2 * n - 6 || seen > 2 * n + 8) begin
            num_errors++;
            $display("[FAIL] expiry cycles expected %0d seen %0d", 2 * n, seen);
        end
    endtask : chk_time

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'h1;
        do begin
            @(posedge core_clk);
            n++;
        end while (ack !== 1'b1);
        chk("bus ack latency", 32'h2, n);
        wb_q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge core_clk);
    endtask : wb

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string name);
        wb(1'b0, a, 32'h0);
        chk(name, e, wb_q);
    endtask : rd

    // first edge is skipped so a pulse already seen is not counted twice
    task automatic wait_rst(input int lim);
        c = 0;
        do begin
            @(posedge core_clk);
            c++;
        end while (wdt_rst !== 1'b1 && c < lim);
    endtask : wait_rst

    // one-cycle strobe on the core model's kick, its go, or the recovery input
    task automatic pulse(input int w);
        kick_req <= (w == P_KICK);
        go <= (w == P_GO);
        recov <= (w == P_RECOV);
        @(posedge core_clk);
        kick_req <= 1'b0;
        go <= 1'b0;
        recov <= 1'b0;
    endtask : pulse

    task automatic do_reset(input logic s);
        rst_b <= 1'b0;
        strap <= s;
        halt <= 1'b0;
        stop <= 1'b0;
        repeat (20) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
    endtask : do_reset

    initial begin
        do_reset(1'b0);
        rd(8'h3c, 32'h0, "mode readback");
        rd(8'h48, 32'h0, "count after reset");
        rd(8'h7c, 32'h0, "unmapped read");
        wait_rst(1200);
        chk("idle no expiry", 1200, c);
        pulse(P_KICK);
        wait_rst(5000);
        chk_time(256, c);
        foreach (rows[i]) begin
            do_reset(1'b0);
            wb(1'b1, 8'h3c, {24'h0, rows[i].mode});
            pulse(P_KICK);
            wait_rst(5000);
            chk_time(rows[i].n, c);
            @(posedge core_clk);
            chk("irq masked", 32'h0, {31'h0, irq});
            rd(8'h40, 32'h1, "status expired");
        end
        do_reset(1'b0);
        wb(1'b1, 8'h44, 32'h3);
        rd(8'h44, 32'h3, "mask readback");
        pulse(P_GO);
        repeat (WIN + 4) @(posedge core_clk);
        wb(1'b1, 8'h3c, 32'h0c);
        chk("irq on reject", 32'h1, {31'h0, irq});
        rd(8'h40, 32'h2, "status rejected");
        @(posedge core_clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        pulse(P_KICK);
        wait_rst(5000);
        chk_time(256, c);
        pulse(P_GO);
        repeat (WIN + 4) @(posedge core_clk);
        pulse(P_RECOV);
        wb(1'b1, 8'h3c, 32'h0c);
        rd(8'h40, 32'h1, "status no reject");
        pulse(P_KICK);
        wait_rst(5000);
        chk_time(128, c);
        do_reset(1'b0);
        pulse(P_KICK);
        repeat (400) @(posedge core_clk);
        pulse(P_KICK);
        wait_rst(5000);
        chk_time(256, c);
        // third pass: crystal selected, runs in stop, but the crystal is halted there
        for (int k = 0; k < 3; k++) begin
            do_reset(1'b0);
            wb(1'b1, 8'h3c, (k == 0) ? 32'h09 : ((k == 1) ? 32'h05 : 32'h1d));
            halt <= (k == 0);
            stop <= (k != 0);
            pulse(P_KICK);
            wait_rst(1200);
            chk("frozen", 1200, c);
            rd(8'h48, 32'h1000, "frozen count");
            halt <= 1'b0;
            stop <= 1'b0;
            wait_rst(5000);
            chk_time(256, c);
        end
        do_reset(1'b1);
        wait_rst(5000);
        chk("auto start", 32'h1, 32'(c <= 520));
        wb(1'b1, 8'h3c, 32'h09);
        halt <= 1'b1;
        wait_rst(5000);
        chk_time(256, c);
        do_reset(1'b1);
        wb(1'b1, 8'h3c, 32'h19);
        halt <= 1'b1;
        wait_rst(1200);
        chk("strap crystal halt", 1200, c);
        end_sim();
    end
endmodule : tb_watchdog_timer_with_mode_control

/* File: wdm_core_model.sv */
`timescale 1ns/1ps
module wdm_core_model (
    input wire logic i_core_clk,
    input wire logic i_kick,
    input wire logic i_go,
    input wire logic i_stop_mode,
    output logic o_wdt_instr,
    output logic o_first_instr,
    output logic o_rc_osc,
    output logic o_crystal_input_pin
);
    initial begin
        o_wdt_instr = 1'b0;
        o_first_instr = 1'b0;
        o_rc_osc = 1'b0;
        o_crystal_input_pin = 1'b0;
    end

    // one instruction per request, never stretched
    always @(posedge i_core_clk) begin
        o_wdt_instr <= i_kick;
        o_first_instr <= i_go;
        o_rc_osc <= ~o_rc_osc;
        // crystal halts in stop, only the rc keeps ticking there
        if (!i_stop_mode) begin
            o_crystal_input_pin <= ~o_crystal_input_pin;
        end
    end
endmodule : wdm_core_model

/* File: wdm_edge_tick.sv */
`timescale 1ns/1ps

module wdm_edge_tick (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_level,
    output logic o_tick
);

    logic prev;

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            prev <= 1'b0;
            o_tick <= 1'b0;
        end else begin
            prev <= i_level;
            o_tick <= i_level & ~prev;
        end
    end

endmodule : wdm_edge_tick

/* File: wdm_map.svh */
`ifndef WDM_MAP_SVH
`define WDM_MAP_SVH

// register indices; byte address is four times the index
`define WDM_IDX_MODE 6'h0f
`define WDM_IDX_STATUS 6'h10
`define WDM_IDX_MASK 6'h11
`define WDM_IDX_COUNT 6'h12

// mode register fields
`define WDM_MODE_RESET 5'h0d
`define WDM_TAP_LSB 0
`define WDM_TAP_MSB 1
`define WDM_BIT_HALT 2
`define WDM_BIT_STOP 3
`define WDM_BIT_XTAL 4
`define WDM_MODE_MSB 4

// status and mask fields
`define WDM_ST_EXPIRED 0
`define WDM_ST_REJECT 1
`define WDM_ST_MSB 1
`define WDM_ST_RESET 2'h0

// timing
`define WDM_WIN_CYCLES 64
`define WDM_TERM_TAP0 12'h080
`define WDM_TERM_TAP1 12'h100
`define WDM_TERM_TAP2 12'h200
`define WDM_TERM_TAP3 12'h800

`endif

/* File: wdm_pkg.sv */
package wdm_pkg;

    typedef enum logic [1:0] {
        WDM_TAP_128 = 2'b00,
        WDM_TAP_256 = 2'b01,
        WDM_TAP_512 = 2'b10,
        WDM_TAP_2048 = 2'b11
    } wdm_tap_t;

    typedef enum logic [1:0] {
        WDM_WIN_WAIT = 2'b00,
        WDM_WIN_COUNT = 2'b01,
        WDM_WIN_CLOSED = 2'b10
    } wdm_win_state_t;

endpackage : wdm_pkg

/* File: wdm_watchdog.sv */
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ps
`include "wdm_map.svh"

// Summary of operation
// - terminal count resets the device
// - tap picks 128/256/512/2048 tick period
// - tap defaults to code 01 after reset
// - bit 2 keeps counting in halt
// - bit 3 keeps counting in stop on RC only; crystal ticks are gated off in stop
// - bit 4 picks crystal pin or RC
// - mode writes taken until 64 cycles after the first instruction
// - mode register write-only, index 0x0f
// - permanent option starts timer out of reset
// - refresh instruction restarts the period
// - off until instruction, reset disables it
// - permanent with RC never stops
// - permanent on the crystal still follows halt/stop bits
module wdm_watchdog
    import wdm_pkg::*;
#(
    parameter int WIN_CYCLES = `WDM_WIN_CYCLES
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic i_wdt_instr,
    input wire logic i_first_instr,
    input wire logic i_stop_wake_recovery,
    input wire logic i_halt_mode,
    input wire logic i_stop_mode,
    input wire logic i_rc_osc,
    input wire logic i_crystal_input_pin,
    input wire logic i_perm_enable_opt,
    output logic o_wdt_reset,
    output logic o_irq
);

    localparam int CNT_W = 12;

    initial begin
        if (WIN_CYCLES < 1 || WIN_CYCLES > 4096) begin
            $error("write window length out of range");
        end
    end

    logic [`WDM_MODE_MSB:0] watchdog_mode_config;
    logic [`WDM_ST_MSB:0] status;
    logic [`WDM_ST_MSB:0] mask;
    logic [CNT_W-1:0] watchdog_counter;
    logic enabled;
    logic perm_valid;
    logic perm_latched;
    logic win_open;
    logic rc_tick;
    logic xtal_tick;
    logic tick;
    logic frozen;
    logic run;
    logic expire;
    logic [CNT_W-1:0] term_m1;
    logic req;
    logic [5:0] idx;
    logic mode_wr;
    logic mode_reject;
    logic status_rd;
    logic [`WDM_ST_MSB:0] next_status;
    wdm_tap_t timeout_tap_select;

    wdm_edge_tick u_rc_tick (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_level(i_rc_osc),
        .o_tick(rc_tick)
    );

    wdm_edge_tick u_xtal_tick (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_level(i_crystal_input_pin),
        .o_tick(xtal_tick)
    );

    // an expiry is a watchdog reset, so it reopens the window as well
    wdm_write_window #(
        .WIN_CYCLES(WIN_CYCLES)
    ) u_window (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_rearm(expire | i_stop_wake_recovery),
        .i_first_instr(i_first_instr),
        .o_open(win_open)
    );

    // bus decode
    assign req = i_wb_cyc & i_wb_stb;
    assign idx = i_wb_adr[7:2];
    assign mode_wr = req & o_wb_ack & i_wb_we & i_wb_sel[0] & (idx == `WDM_IDX_MODE);
    assign mode_reject = mode_wr & ~win_open;
    assign status_rd = req & o_wb_ack & ~i_wb_we & (idx == `WDM_IDX_STATUS);

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_wb_ack <= 1'b0;
        end else begin
            o_wb_ack <= req & ~o_wb_ack;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_wb_dat <= 32'h0;
        end else if (req && !o_wb_ack && !i_wb_we) begin
            case (idx)
                `WDM_IDX_STATUS: o_wb_dat <= {30'h0, status};
                `WDM_IDX_MASK: o_wb_dat <= {30'h0, mask};
                `WDM_IDX_COUNT: o_wb_dat <= {19'h0, enabled, watchdog_counter};
                default: o_wb_dat <= 32'h0; // mode register reads nothing
            endcase
        end
    end

    // strap sampled on the first clocked cycle after reset release
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            perm_valid <= 1'b0;
            perm_latched <= 1'b0;
        end else if (!perm_valid) begin
            perm_valid <= 1'b1;
            perm_latched <= i_perm_enable_opt;
        end
    end

    // upper bits are dropped, they have no function
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            watchdog_mode_config <= `WDM_MODE_RESET;
        end else if (mode_wr && win_open) begin
            watchdog_mode_config <= i_wb_dat[`WDM_MODE_MSB:0];
        end
    end

    assign timeout_tap_select = wdm_tap_t'(watchdog_mode_config[`WDM_TAP_MSB:`WDM_TAP_LSB]);

    always_comb begin
        case (timeout_tap_select)
            WDM_TAP_128: term_m1 = `WDM_TERM_TAP0 - 12'h001;
            WDM_TAP_256: term_m1 = `WDM_TERM_TAP1 - 12'h001;
            WDM_TAP_512: term_m1 = `WDM_TERM_TAP2 - 12'h001;
            WDM_TAP_2048: term_m1 = `WDM_TERM_TAP3 - 12'h001;
            default: term_m1 = `WDM_TERM_TAP1 - 12'h001;
        endcase
    end

    // the crystal stops in stop mode, so its ticks cannot reach the chain there
    always_comb begin
        if (watchdog_mode_config[`WDM_BIT_XTAL]) begin
            tick = xtal_tick & ~i_stop_mode;
        end else begin
            tick = rc_tick;
        end
    end

    // permanent on the RC clock overrides the halt/stop bits
    always_comb begin
        frozen = (i_halt_mode & ~watchdog_mode_config[`WDM_BIT_HALT])
            | (i_stop_mode & ~watchdog_mode_config[`WDM_BIT_STOP]);
        if (perm_latched && !watchdog_mode_config[`WDM_BIT_XTAL]) begin
            frozen = 1'b0;
        end
    end

    assign run = enabled & ~frozen;
    assign expire = run & tick & ~i_wdt_instr & (watchdog_counter == term_m1);

    // nothing but reset or expiry clears enable, so software cannot stop it
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            enabled <= 1'b0;
        end else if (!perm_valid) begin
            enabled <= i_perm_enable_opt;
        end else if (expire) begin
            enabled <= perm_latched;
        end else if (i_wdt_instr) begin
            enabled <= 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            watchdog_counter <= '0;
        end else if (i_wdt_instr || expire || !enabled) begin
            watchdog_counter <= '0;
        end else if (run && tick) begin
            watchdog_counter <= watchdog_counter + 12'h001;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_wdt_reset <= 1'b0;
        end else begin
            o_wdt_reset <= expire;
        end
    end

    // set wins over the read that clears
    always_comb begin
        next_status = status;
        // clear only what this read reported; an event caught after capture survives
        if (status_rd) begin
            next_status = status & ~o_wb_dat[`WDM_ST_MSB:0];
        end
        if (expire) begin
            next_status[`WDM_ST_EXPIRED] = 1'b1;
        end
        if (mode_reject) begin
            next_status[`WDM_ST_REJECT] = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            status <= `WDM_ST_RESET;
        end else begin
            status <= next_status;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            mask <= `WDM_ST_RESET;
        end else if (req && o_wb_ack && i_wb_we && i_wb_sel[0] && idx == `WDM_IDX_MASK) begin
            mask <= i_wb_dat[`WDM_ST_MSB:0];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(next_status & mask);
        end
    end

    default clocking cb @(posedge i_core_clk);
    endclocking

    default disable iff (!i_rst_b);

    sequence s_refresh;
        i_wdt_instr && enabled;
    endsequence

    sequence s_counter_cleared;
        watchdog_counter == 12'h000;
    endsequence

    a_expiry_reset: assert property (expire |=> o_wdt_reset ##1 !o_wdt_reset)
        else $error("expiry did not give a one-cycle reset pulse");

    a_tap_terminal: assert property ($rose(o_wdt_reset) |->
        $past(watchdog_counter) == $past(term_m1))
        else $error("reset did not come at the tap count");

    a_tap_default: assert property (!$past(i_rst_b) |->
        watchdog_mode_config == `WDM_MODE_RESET)
        else $error("mode register not at default after reset");

    a_halt_freeze: assert property (enabled && i_halt_mode
        && !watchdog_mode_config[`WDM_BIT_HALT]
        && !(perm_latched && !watchdog_mode_config[`WDM_BIT_XTAL]) && !i_wdt_instr
        |=> watchdog_counter == $past(watchdog_counter))
        else $error("counter moved in halt with halt bit clear");

    a_stop_freeze: assert property (enabled && i_stop_mode
        && !watchdog_mode_config[`WDM_BIT_STOP]
        && !(perm_latched && !watchdog_mode_config[`WDM_BIT_XTAL]) && !i_wdt_instr
        |=> watchdog_counter == $past(watchdog_counter))
        else $error("counter moved in stop with stop bit clear");

    a_source_select: assert property (i_stop_mode
        && watchdog_mode_config[`WDM_BIT_XTAL] |-> !tick)
        else $error("crystal ticked the chain in stop mode");

    a_window_guard: assert property (mode_wr && !win_open
        |=> watchdog_mode_config == $past(watchdog_mode_config) && status[`WDM_ST_REJECT])
        else $error("mode changed outside the write window");

    a_write_only_read: assert property (req && !o_wb_ack && !i_wb_we
        && idx == `WDM_IDX_MODE |=> o_wb_ack && o_wb_dat == 32'h0)
        else $error("mode register read returned data");

    a_perm_autostart: assert property ($rose(perm_valid) && perm_latched |-> enabled)
        else $error("permanent option did not start the timer");

    a_refresh_restart: assert property (s_refresh |=>
        s_counter_cleared ##1 watchdog_counter <= 12'h001)
        else $error("refresh did not restart the period");

    a_off_until_instr: assert property (perm_valid && !enabled && !i_wdt_instr
        |=> !enabled)
        else $error("timer started without the instruction");

    a_perm_never_off: assert property (perm_latched && enabled
        |=> enabled)
        else $error("permanent timer was disabled");

endmodule : wdm_watchdog

/* File: wdm_write_window.sv */
`timescale 1ns/1ps

module wdm_write_window
    import wdm_pkg::*;
#(
    parameter int WIN_CYCLES = 64
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_rearm,
    input wire logic i_first_instr,
    output logic o_open
);

    localparam int CW = $clog2(WIN_CYCLES + 1);

    initial begin
        if (WIN_CYCLES < 1) begin
            $error("write window needs at least one cycle");
        end
    end

    wdm_win_state_t state;
    logic [CW-1:0] cnt;

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            state <= WDM_WIN_WAIT;
            cnt <= '0;
        end else if (i_rearm) begin
            state <= WDM_WIN_WAIT;
            cnt <= '0;
        end else begin
            case (state)
                WDM_WIN_WAIT: begin
                    if (i_first_instr) begin
                        state <= WDM_WIN_COUNT;
                        cnt <= CW'(1);
                    end
                end
                WDM_WIN_COUNT: begin
                    if (cnt == CW'(WIN_CYCLES)) begin
                        state <= WDM_WIN_CLOSED;
                    end else begin
                        cnt <= cnt + CW'(1);
                    end
                end
                WDM_WIN_CLOSED: begin
                    state <= WDM_WIN_CLOSED;
                end
                default: begin
                    state <= WDM_WIN_CLOSED;
                end
            endcase
        end
    end

    // open before the first instruction too, so mode writes are taken then as well
    assign o_open = (state != WDM_WIN_CLOSED);

endmodule : wdm_write_window
